// ### shared/fep_pkg.sv
// fep_pkg: code groups, state types and line scrambler helpers
package fep_pkg;
  // ----------------------------------------------------------------
  // code groups
  // ----------------------------------------------------------------
  localparam int         FEP_NIB_CODES = 16;
  localparam logic [4:0] FEP_CG_IDLE   = 5'h1F;
  localparam logic [4:0] FEP_CG_J      = 5'h18;
  localparam logic [4:0] FEP_CG_K      = 5'h11;
  localparam logic [4:0] FEP_CG_T      = 5'h0D;
  localparam logic [4:0] FEP_CG_R      = 5'h07;
  localparam logic [4:0] FEP_CG_H      = 5'h04;
  localparam logic [3:0] FEP_PRE_NIB   = 4'h5;
  localparam logic [3:0] FEP_BAD_NIB   = 4'h0;
  localparam logic [4:0] FEP_ENC [FEP_NIB_CODES] = '{
    5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
    5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};

  // ----------------------------------------------------------------
  // scrambler, widths and counts
  // ----------------------------------------------------------------
  localparam logic [10:0] FEP_SCR_SEED  = 11'h7FF;
  localparam int          FEP_TAP_HI    = 10;
  localparam int          FEP_TAP_LO    = 8;
  localparam int          FEP_SYM_MSB   = 4;
  localparam int          FEP_NIB_MSB   = 3;
  localparam int          FEP_WIN_W     = 10;
  localparam logic [4:0]  FEP_LOCK_BITS = 5'h1F;
  localparam logic [2:0]  FEP_SYM_LAST  = 3'h4;
  localparam logic [2:0]  FEP_PRE2_AT   = 3'h2;
  localparam logic [1:0]  FEP_NIB_LAST  = 2'h3;
  localparam logic [2:0]  FEP_MAN_LAST  = 3'h7;
  localparam logic [2:0]  FEP_MAN_RDY   = 3'h6;
  localparam logic [3:0]  FEP_PD_WAIT   = 4'hF;

  // ----------------------------------------------------------------
  // ability and crossing bit positions
  // ----------------------------------------------------------------
  localparam int FEP_AB_10H  = 0;
  localparam int FEP_AB_10F  = 1;
  localparam int FEP_AB_100H = 2;
  localparam int FEP_AB_100F = 3;
  localparam int FEP_X_ACT   = 0;
  localparam int FEP_X_LOCK  = 1;
  localparam int FEP_X_SD    = 2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {SYM_DATA, SYM_IDLE, SYM_J, SYM_K, SYM_T,
                            SYM_R, SYM_H, SYM_BAD} fep_sym_t;
  typedef enum logic [2:0] {TX_IDLE, TX_K, TX_DATA, TX_R,
                            TX_MAN} fep_tx_t;
  typedef struct packed {
    fep_sym_t   kind;
    logic [3:0] nib;
  } fep_dec_t;
  typedef struct packed {
    logic [3:0] nib;
    logic       dv;
    logic       er;
    logic       vld;
  } fep_rxmii_t;

  function automatic logic fep_ks(input logic [10:0] s);
    return s[FEP_TAP_HI] ^ s[FEP_TAP_LO];
  endfunction

  // scramble one code group, msb first; returns {next state, data}
  function automatic logic [15:0] fep_scr5(input logic [10:0] s,
                                           input logic [4:0]  d);
    logic [10:0] t;
    logic [4:0]  o;
    logic        k;
    t = s;
    o = 5'h00;
    for (int i = FEP_SYM_MSB; i >= 0; i--) begin
      k = fep_ks(t);
      o[i] = d[i] ^ k;
      t = {t[FEP_TAP_HI-1:0], k};
    end
    return {t, o};
  endfunction

  function automatic fep_dec_t fep_decode(input logic [4:0] cg);
    fep_dec_t d;
    d.kind = SYM_BAD;
    d.nib  = FEP_BAD_NIB;
    for (int i = 0; i < FEP_NIB_CODES; i++) begin
      if (cg == FEP_ENC[i]) begin
        d.kind = SYM_DATA;
        d.nib  = 4'(i);
      end
    end
    case (cg)
      FEP_CG_IDLE: d.kind = SYM_IDLE;
      FEP_CG_J:    begin d.kind = SYM_J; d.nib = FEP_PRE_NIB; end
      FEP_CG_K:    begin d.kind = SYM_K; d.nib = FEP_PRE_NIB; end
      FEP_CG_T:    d.kind = SYM_T;
      FEP_CG_R:    d.kind = SYM_R;
      FEP_CG_H:    d.kind = SYM_H;
      default:     ;
    endcase
    return d;
  endfunction
endpackage

// ### logic/fep_codec.sv
// fep_codec: 10/100 line coding, alignment, carrier and link resolution
`timescale 1ns/1ps
module fep_codec
  import fep_pkg::*;
(
  input  logic       clk,
  input  logic       nrst,
  input  logic       ce,
  input  logic       rx_clk,
  input  logic       rx_line,
  input  logic       rx_sig_det,
  input  logic       tx_en,
  input  logic       tx_er,
  input  logic [3:0] tx_nib,
  input  logic       an_en,
  input  logic [3:0] an_loc_abil,
  input  logic [3:0] an_lp_abil,
  input  logic       an_lp_vld,
  output logic [4:0] tx_cg,
  output logic       tx_man,
  output logic       tx_rdy,
  output fep_rxmii_t rx_mii,
  output logic       crs,
  output logic       col,
  output logic [4:0] an_adv,
  output logic       spd100,
  output logic       fdx,
  output logic       link_up
);
  // ----------------------------------------------------------------
  // state of both domains
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        ce_s1, ce_s2, spd_s1, spd_s2;
    logic        sd_s1, sd_s2, sd_s3, sd_st;
    logic        nrzi_q;
    logic [10:0] lfsr;
    logic [4:0]  lock_cnt;
    logic        locked;
    logic [9:0]  win;
    logic        in_frame;
    logic [2:0]  bitcnt;
    logic        pre_pend, seen_t;
    logic        m_act, m_half, m_first, m_er;
    logic [1:0]  m_bc;
    logic [3:0]  m_nib;
    fep_rxmii_t  mii;
    logic        act;
  } fep_link_t;

  typedef struct packed {
    logic [2:0]  x_s1, x_s2, x_s3, x_st;
    fep_tx_t     tst;
    logic [10:0] lfsr;
    logic [4:0]  plain;
    logic [4:0]  cg;
    logic        man;
    logic [2:0]  mcnt;
    logic [3:0]  mnib;
    logic        rdy;
    logic        crs, col;
    logic [3:0]  lp;
    logic        neg, ack, spd100, fdx, link;
    logic [3:0]  pd_cnt;
    logic [4:0]  adv;
  } fep_core_t;

  fep_link_t r, r_nxt;
  fep_core_t c, c_nxt;
  fep_dec_t  dec;
  logic      jk_hit, t_hit, bad_hit;

  // ----------------------------------------------------------------
  // receive side, recovered line clock
  // ----------------------------------------------------------------
  always_comb begin
    logic       sbit, ks, dbit, bnd;
    logic [9:0] w;
    r_nxt = r;
    sbit  = rx_line ^ r.nrzi_q;
    ks    = fep_ks(r.lfsr);
    dbit  = sbit ^ ks;
    w     = {r.win[FEP_WIN_W-2:0], dbit};
    dec   = fep_decode(w[FEP_SYM_MSB:0]);
    bnd   = r.ce_s2 && r.spd_s2 && r.in_frame && r.locked &&
            r.bitcnt == FEP_SYM_LAST;
    jk_hit  = r.ce_s2 && r.spd_s2 && !r.in_frame && r.locked &&
              w == {FEP_CG_J, FEP_CG_K};
    t_hit   = bnd && !r.seen_t && dec.kind == SYM_T;
    bad_hit = bnd && !r.seen_t &&
              (dec.kind == SYM_BAD || dec.kind == SYM_H ||
               dec.kind == SYM_J || dec.kind == SYM_K);
    r_nxt.ce_s1  = ce;
    r_nxt.ce_s2  = r.ce_s1;
    r_nxt.spd_s1 = c.spd100;
    r_nxt.spd_s2 = r.spd_s1;
    if (r.ce_s2) begin
      r_nxt.sd_s1   = rx_sig_det;
      r_nxt.sd_s2   = r.sd_s1;
      r_nxt.sd_s3   = r.sd_s2;
      if (r.sd_s2 == r.sd_s3)
        r_nxt.sd_st = r.sd_s3;
      r_nxt.mii.vld = 1'b0;
      r_nxt.nrzi_q  = rx_line;
      // descrambler locks on idle, where the plain stream is all ones
      if (r.locked)
        r_nxt.lfsr = {r.lfsr[FEP_TAP_HI-1:0], ks};
      else
        r_nxt.lfsr = {r.lfsr[FEP_TAP_HI-1:0], ~sbit};
      if (!r.sd_st) begin
        r_nxt.lock_cnt = '0;
        r_nxt.locked   = 1'b0;
      end else if (!r.locked) begin
        r_nxt.lock_cnt = (~sbit == ks) ? r.lock_cnt + 5'h01 : 5'h00;
        if (r.lock_cnt == FEP_LOCK_BITS)
          r_nxt.locked = 1'b1;
      end
      r_nxt.win = w;
      if (r.spd_s2) begin
        r_nxt.m_act = 1'b0;
        if (!r.in_frame) begin
          if (jk_hit) begin
            r_nxt.in_frame = 1'b1;
            r_nxt.bitcnt   = '0;
            r_nxt.pre_pend = 1'b1;
            r_nxt.seen_t   = 1'b0;
            r_nxt.mii      = '{nib: FEP_PRE_NIB, dv: 1'b1,
                               er: 1'b0, vld: 1'b1};
          end
        end else if (!r.locked) begin
          r_nxt.in_frame = 1'b0;
          r_nxt.mii.dv   = 1'b0;
        end else if (r.bitcnt == FEP_SYM_LAST) begin
          r_nxt.bitcnt = '0;
          if (r.seen_t) begin
            // anything but R after T ends the frame in error
            r_nxt.in_frame = 1'b0;
            r_nxt.mii.dv   = 1'b0;
            r_nxt.mii.er   = dec.kind != SYM_R;
            r_nxt.mii.vld  = dec.kind != SYM_R;
          end else begin
            case (dec.kind)
              SYM_DATA: r_nxt.mii = '{nib: dec.nib, dv: 1'b1,
                                      er: 1'b0, vld: 1'b1};
              SYM_T:    r_nxt.seen_t = 1'b1;
              SYM_IDLE: begin
                r_nxt.in_frame = 1'b0;
                r_nxt.mii      = '{nib: FEP_BAD_NIB, dv: 1'b0,
                                   er: 1'b1, vld: 1'b1};
              end
              default:  r_nxt.mii = '{nib: FEP_BAD_NIB, dv: 1'b1,
                                      er: 1'b1, vld: 1'b1};
            endcase
          end
        end else begin
          r_nxt.bitcnt = r.bitcnt + 3'h1;
          if (r.pre_pend && r.bitcnt == FEP_PRE2_AT) begin
            r_nxt.pre_pend = 1'b0;
            r_nxt.mii      = '{nib: FEP_PRE_NIB, dv: 1'b1,
                               er: 1'b0, vld: 1'b1};
          end
        end
        r_nxt.act = r_nxt.in_frame;
      end else begin
        // 10 Mb/s: one line clock per Manchester half bit
        r_nxt.in_frame = 1'b0;
        if (!r.sd_st) begin
          r_nxt.m_act  = 1'b0;
          r_nxt.mii.dv = 1'b0;
        end else if (!r.m_act) begin
          r_nxt.m_act  = 1'b1;
          r_nxt.m_half = 1'b0;
          r_nxt.m_bc   = '0;
          r_nxt.m_er   = 1'b0;
        end else begin
          r_nxt.m_half = ~r.m_half;
          if (!r.m_half) begin
            r_nxt.m_first = rx_line;
          end else begin
            r_nxt.m_nib = {rx_line, r.m_nib[FEP_NIB_MSB:1]};
            r_nxt.m_er  = r.m_er | (rx_line == r.m_first);
            r_nxt.m_bc  = r.m_bc + 2'h1;
            if (r.m_bc == FEP_NIB_LAST) begin
              r_nxt.m_er = 1'b0;
              r_nxt.mii  = '{nib: r_nxt.m_nib, dv: 1'b1,
                             er: r.m_er | (rx_line == r.m_first),
                             vld: 1'b1};
            end
          end
        end
        r_nxt.act = r_nxt.m_act;
      end
    end
  end

  always_ff @(posedge rx_clk or negedge nrst) begin
    if (!nrst)
      r <= '0;
    else
      r <= r_nxt;
  end

  // ----------------------------------------------------------------
  // transmit, carrier, collision and link resolution
  // ----------------------------------------------------------------
  always_comb begin
    logic       tact, ract, sd;
    logic [3:0] com;
    c_nxt = c;
    tact  = c.tst != TX_IDLE;
    ract  = c.x_st[FEP_X_ACT];
    sd    = c.x_st[FEP_X_SD];
    com   = an_loc_abil & an_lp_abil;
    c_nxt.x_s1[FEP_X_ACT]  = r.act;
    c_nxt.x_s1[FEP_X_LOCK] = r.locked;
    c_nxt.x_s1[FEP_X_SD]   = r.sd_st;
    c_nxt.x_s2 = c.x_s1;
    c_nxt.x_s3 = c.x_s2;
    for (int i = 0; i <= FEP_X_SD; i++) begin
      if (c.x_s2[i] == c.x_s3[i])
        c_nxt.x_st[i] = c.x_s3[i];
    end
    case (c.tst)
      TX_IDLE: begin
        c_nxt.plain = FEP_CG_IDLE;
        c_nxt.rdy   = 1'b1;
        if (tx_en && c.spd100) begin
          c_nxt.plain = FEP_CG_J;
          c_nxt.tst   = TX_K;
        end else if (tx_en) begin
          c_nxt.tst  = TX_MAN;
          c_nxt.mnib = tx_nib;
          c_nxt.mcnt = '0;
          c_nxt.rdy  = 1'b0;
        end
      end
      TX_K: begin
        c_nxt.plain = FEP_CG_K;
        c_nxt.tst   = TX_DATA;
      end
      TX_DATA: begin
        if (tx_en) begin
          c_nxt.plain = tx_er ? FEP_CG_H : FEP_ENC[tx_nib];
        end else begin
          c_nxt.plain = FEP_CG_T;
          c_nxt.tst   = TX_R;
        end
      end
      TX_R: begin
        c_nxt.plain = FEP_CG_R;
        c_nxt.tst   = TX_IDLE;
      end
      TX_MAN: begin
        c_nxt.mcnt = c.mcnt + 3'h1;
        if (c.mcnt == FEP_MAN_RDY)
          c_nxt.rdy = 1'b1;
        if (c.mcnt == FEP_MAN_LAST) begin
          if (tx_en) begin
            c_nxt.mnib = tx_nib;
            c_nxt.rdy  = 1'b0;
          end else begin
            c_nxt.tst  = TX_IDLE;
          end
        end
      end
      default: c_nxt.tst = TX_IDLE;
    endcase
    {c_nxt.lfsr, c_nxt.cg} = fep_scr5(c.lfsr, c_nxt.plain);
    // first half carries the inverse of the bit, lsb first
    c_nxt.man = (c_nxt.tst == TX_MAN) &&
                (c_nxt.mnib[2'(c_nxt.mcnt >> 1)] ^ !c_nxt.mcnt[0]);
    c_nxt.crs = ract | (tact & !c.fdx);
    c_nxt.col = tact & ract & !c.fdx;
    if (!sd) begin
      c_nxt.neg    = 1'b0;
      c_nxt.ack    = 1'b0;
      c_nxt.link   = 1'b0;
      c_nxt.pd_cnt = '0;
    end else if (an_en && an_lp_vld) begin
      c_nxt.lp   = an_lp_abil;
      c_nxt.neg  = 1'b1;
      c_nxt.ack  = 1'b1;
      c_nxt.link = |com;
      c_nxt.spd100 = com[FEP_AB_100F] | com[FEP_AB_100H];
      c_nxt.fdx    = com[FEP_AB_100F] |
                     (!com[FEP_AB_100H] & com[FEP_AB_10F]);
    end else if (!c.neg && !c.link) begin
      if (c.pd_cnt != FEP_PD_WAIT) begin
        c_nxt.pd_cnt = c.pd_cnt + 4'h1;
      end else if (c.x_st[FEP_X_LOCK] &&
                   (an_loc_abil[FEP_AB_100F] | an_loc_abil[FEP_AB_100H]))
      begin
        c_nxt.link   = 1'b1;
        c_nxt.spd100 = 1'b1;
        c_nxt.fdx    = 1'b0;
      end else if (!c.x_st[FEP_X_LOCK] &&
                   (an_loc_abil[FEP_AB_10F] | an_loc_abil[FEP_AB_10H]))
      begin
        c_nxt.link   = 1'b1;
        c_nxt.spd100 = 1'b0;
        c_nxt.fdx    = 1'b0;
      end
    end
    c_nxt.adv = {c_nxt.ack, an_loc_abil};
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      c       <= '0;
      c.lfsr  <= FEP_SCR_SEED;
      c.plain <= FEP_CG_IDLE;
      c.rdy   <= 1'b1;
    end else if (ce) begin
      c <= c_nxt;
    end
  end

  assign tx_cg   = c.cg;
  assign tx_man  = c.man;
  assign tx_rdy  = c.rdy;
  assign rx_mii  = r.mii;
  assign crs     = c.crs;
  assign col     = c.col;
  assign an_adv  = c.adv;
  assign spd100  = c.spd100;
  assign fdx     = c.fdx;
  assign link_up = c.link;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_sof_go;
    c.tst == TX_IDLE && tx_en && c.spd100 && ce;
  endsequence
  sequence s_eof_go;
    c.tst == TX_DATA && !tx_en && ce;
  endsequence

  property p_tx_sof;
    @(posedge clk) disable iff (!nrst)
      s_sof_go ##1 ce |-> c.plain == FEP_CG_J ##1 c.plain == FEP_CG_K;
  endproperty
  a_tx_sof: assert property (p_tx_sof) else $error("no J/K at start");
  property p_tx_eof;
    @(posedge clk) disable iff (!nrst)
      s_eof_go ##1 ce |-> c.plain == FEP_CG_T ##1 c.plain == FEP_CG_R;
  endproperty
  a_tx_eof: assert property (p_tx_eof) else $error("no T/R at end");
  property p_tx_map;
    @(posedge clk) disable iff (!nrst)
      c.tst == TX_DATA && tx_en && !tx_er && ce
      |=> c.plain == FEP_ENC[$past(tx_nib)];
  endproperty
  a_tx_map: assert property (p_tx_map) else $error("bad encode");
  property p_col_fdx;
    @(posedge clk) disable iff (!nrst) c.fdx && ce |=> !c.col;
  endproperty
  a_col_fdx: assert property (p_col_fdx) else $error("col in fdx");
  property p_col_half;
    @(posedge clk) disable iff (!nrst)
      !c.fdx && c.tst != TX_IDLE && c.x_st[FEP_X_ACT] && ce |=> c.col;
  endproperty
  a_col_half: assert property (p_col_half) else $error("col missed");
  property p_crs_fdx;
    @(posedge clk) disable iff (!nrst)
      c.fdx && !c.x_st[FEP_X_ACT] && ce |=> !c.crs;
  endproperty
  a_crs_fdx: assert property (p_crs_fdx) else $error("crs on tx");
  property p_an_prio;
    @(posedge clk) disable iff (!nrst)
      an_en && an_lp_vld && c.x_st[FEP_X_SD] && ce &&
      an_loc_abil[FEP_AB_100F] && an_lp_abil[FEP_AB_100F]
      |=> c.spd100 && c.fdx && c.link && c.ack;
  endproperty
  a_an_prio: assert property (p_an_prio) else $error("bad priority");
  property p_man;
    @(posedge clk) disable iff (!nrst)
      c.tst == TX_MAN && c.mcnt[0] && $past(ce) |-> c.man != $past(c.man);
  endproperty
  a_man: assert property (p_man) else $error("no mid-bit edge");
  property p_rx_sof;
    @(posedge rx_clk) disable iff (!nrst)
      jk_hit |=> r.mii.vld && r.mii.dv && r.mii.nib == FEP_PRE_NIB;
  endproperty
  a_rx_sof: assert property (p_rx_sof) else $error("no preamble");
  property p_rx_pre2;
    @(posedge rx_clk) disable iff (!nrst)
      jk_hit ##1 r.ce_s2 [*3] |=> r.mii.vld && r.mii.nib == FEP_PRE_NIB;
  endproperty
  a_rx_pre2: assert property (p_rx_pre2) else $error("no 2nd pre");
  property p_rx_strip;
    @(posedge rx_clk) disable iff (!nrst) t_hit |=> !r.mii.vld;
  endproperty
  a_rx_strip: assert property (p_rx_strip) else $error("T leaked");
  property p_rx_bad;
    @(posedge rx_clk) disable iff (!nrst)
      bad_hit |=> r.mii.vld && r.mii.er && r.mii.dv;
  endproperty
  a_rx_bad: assert property (p_rx_bad) else $error("no rx error");
endmodule

// ### tb/fep_partner.sv
// fep_partner: remote link end driving the scrambled NRZI receive line
`timescale 1ns/1ps
module fep_partner
  import fep_pkg::*;
(
  output logic rx_clk,
  output logic rx_line,
  output logic rx_sig_det
);
  logic [10:0] scr_r = 11'h2A5;
  logic        kb;

  initial begin
    rx_clk = 1'b0;
    rx_line = 1'b0;
    rx_sig_det = 1'b0;
  end

  task automatic set_sd(input logic on);
    rx_sig_det = on;
  endtask

  // one group msb first; the clock runs only while bits go out
  task automatic send_cg(input logic [4:0] cg);
    for (int i = 4; i >= 0; i--) begin
      kb = scr_r[10] ^ scr_r[8];
      scr_r = {scr_r[9:0], kb};
      rx_line = rx_line ^ cg[i] ^ kb;
      #3 rx_clk = 1'b1;
      #3 rx_clk = 1'b0;
    end
  endtask

  task automatic send_idle(input int n);
    repeat (n) send_cg(FEP_CG_IDLE);
  endtask

  task automatic send_frame(input logic [4:0] b[$]);
    send_idle(8);
    send_cg(FEP_CG_J);
    send_cg(FEP_CG_K);
    foreach (b[i]) send_cg(b[i]);
    send_cg(FEP_CG_T);
    send_cg(FEP_CG_R);
    send_idle(4);
  endtask
endmodule

// ### tb/fep_codec_test.sv
// fep_codec_test: self-checking bench for the 10/100 codec
`timescale 1ns/1ps
module fep_codec_test
  import fep_pkg::*;
();
  logic        clk = 1'b0;
  logic        nrst, ce, tx_en, tx_er, an_en, an_lp_vld;
  logic        rx_clk, rx_line, rx_sig_det, tx_man, tx_rdy;
  logic        crs, col, spd100, fdx, link_up, kb, ce_q = 1'b0;
  logic [3:0]  tx_nib, an_loc_abil, an_lp_abil;
  logic [4:0]  tx_cg, an_adv, dg, hold_cg, txq[$], body[$];
  logic [10:0] ks_r;
  logic [31:0] rnd = 32'h806C48FA;
  fep_rxmii_t  rx_mii, rxq[$], expq[$];
  int          failures = 0, tests_run = 0, cyc = 0, learn = 0;
  logic [4:0]  bad_cg [10] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h05,
                               5'h06, 5'h08, 5'h0C, 5'h10, 5'h19};

  always #50 clk = ~clk;

  fep_codec fep_codec_inst (.clk, .nrst, .ce, .rx_clk, .rx_line,
    .rx_sig_det, .tx_en, .tx_er, .tx_nib, .an_en, .an_loc_abil,
    .an_lp_abil, .an_lp_vld, .tx_cg, .tx_man, .tx_rdy, .rx_mii, .crs,
    .col, .an_adv, .spd100, .fdx, .link_up);
  fep_partner fep_partner_inst (.rx_clk, .rx_line, .rx_sig_det);

  // ----------------------------------------------------------------
  // helpers and monitors
  // ----------------------------------------------------------------
  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic step;
    @(posedge clk);
    #1;
  endtask

  task automatic note(input logic ok, input string what);
    tests_run++;
    if (!ok) begin
      failures++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask

  task automatic chk_cg(input logic [4:0] g, input logic [4:0] e);
    note(g === e, "code group");
  endtask

  task automatic chk_bit(input logic g, input logic e);
    note(g === e, "flag");
  endtask

  task automatic chk_rx(input fep_rxmii_t g, input fep_rxmii_t e);
    note(g === e, "receive nibble");
  endtask

  task automatic conclude;
    $display("checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // keystream learned from three idle groups, then predicted
  always @(negedge clk) begin
    cyc++;
    if (ce_q) begin
      for (int i = 4; i >= 0; i--) begin
        kb = learn < 3 ? ~tx_cg[i] : ks_r[10] ^ ks_r[8];
        dg[i] = tx_cg[i] ^ kb;
        ks_r = {ks_r[9:0], kb};
      end
      if (learn < 3) learn++;
      else txq.push_back(dg);
    end
    ce_q = ce & nrst;
    if (cyc == 2000) begin
      failures++;
      conclude();
    end
  end

  always @(negedge rx_clk) if (rx_mii.vld === 1'b1) rxq.push_back(rx_mii);

  task automatic rand_body(input int n);
    repeat (n) begin
      rnd = nxt(rnd);
      body.push_back(FEP_ENC[rnd[3:0]]);
    end
  endtask

  task automatic rx_frame;
    fep_rxmii_t x;
    // a speed change needs two line clocks to cross
    fep_partner_inst.send_idle(2);
    rxq = {};
    x = '{FEP_PRE_NIB, 1'b1, 1'b0, 1'b1};
    expq = '{x, x};
    foreach (body[j]) begin
      x = '{FEP_BAD_NIB, 1'b1, 1'b1, 1'b1};
      for (int i = 0; i < 16; i++)
        if (FEP_ENC[i] == body[j]) x = '{4'(i), 1'b1, 1'b0, 1'b1};
      expq.push_back(x);
    end
    fep_partner_inst.send_frame(body);
    chk_bit(rx_mii.dv, 1'b0);
    chk_bit(rxq.size() == expq.size(), 1'b1);
    foreach (expq[j]) chk_rx(rxq[j], expq[j]);
  endtask

  task automatic an_page(input logic [3:0] loc, input logic [3:0] lp);
    logic [3:0] c;
    step();
    c = loc & lp;
    an_loc_abil = loc;
    an_lp_abil = lp;
    an_lp_vld = 1'b1;
    step();
    an_lp_vld = 1'b0;
    step();
    chk_cg(an_adv, {1'b1, loc});
    chk_bit(link_up, |c);
    if (|c) begin
      chk_bit(spd100, c[3] | c[2]);
      chk_bit(fdx, c[3] | (!c[2] & c[1]));
    end
  endtask

  task automatic tx100;
    logic [4:0] e[$];
    e = '{FEP_CG_J, FEP_CG_K};
    txq = {};
    for (int i = 0; i < 12; i++) begin
      rnd = nxt(rnd);
      tx_nib = rnd[3:0];
      tx_er = (i == 6);
      tx_en = 1'b1;
      if (i > 1) e.push_back(tx_er ? FEP_CG_H : FEP_ENC[tx_nib]);
      step();
    end
    tx_en = 1'b0;
    tx_er = 1'b0;
    e.push_back(FEP_CG_T);
    e.push_back(FEP_CG_R);
    e.push_back(FEP_CG_IDLE);
    repeat (6) step();
    while (txq.size() > e.size() && txq[0] === FEP_CG_IDLE)
      void'(txq.pop_front());
    foreach (e[i]) chk_cg(txq[i], e[i]);
  endtask

  task automatic man_nib(input logic [3:0] n);
    for (int w = 0; w < 20 && tx_rdy !== 1'b1; w++) step();
    tx_nib = n;
    tx_en = 1'b1;
    step();
    tx_en = 1'b0;
    for (int h = 0; h < 8; h++) begin
      chk_bit(tx_man, n[h / 2] ^ !h[0]);
      step();
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {nrst, tx_en, tx_er, an_lp_vld} = '0;
    {ce, an_en} = 2'h3;
    tx_nib = 4'h0;
    an_loc_abil = 4'hF;
    an_lp_abil = 4'h0;
    @(posedge clk);
    fep_partner_inst.send_idle(1);
    repeat (4) @(posedge clk);
    #1;
    nrst = 1'b1;
    step();
    fep_partner_inst.set_sd(1'b1);
    fep_partner_inst.send_idle(40);
    repeat (20) step();
    chk_bit(link_up, 1'b1);
    chk_bit(spd100, 1'b1);
    chk_bit(fdx, 1'b0);
    $display("done parallel detect");
    an_page(4'hF, 4'h0);
    for (int i = 0; i < 8; i++) begin
      rnd = nxt(rnd);
      an_page(rnd[3:0], rnd[7:4]);
    end
    $display("done negotiation");
    an_page(4'hF, 4'h8);
    for (int i = 0; i < 16; i++) body.push_back(FEP_ENC[i]);
    rand_body(8);
    rx_frame();
    body = '{FEP_ENC[9], FEP_CG_H, FEP_ENC[3]};
    foreach (bad_cg[i]) body.push_back(bad_cg[i]);
    rx_frame();
    $display("done receive");
    an_page(4'hF, 4'h8);
    hold_cg = tx_cg;
    ce = 1'b0;
    repeat (3) step();
    chk_cg(tx_cg, hold_cg);
    ce = 1'b1;
    step();
    tx100();
    $display("done transmit");
    for (int fd = 0; fd < 2; fd++) begin
      an_page(4'hC, fd ? 4'h8 : 4'h4);
      tx_en = 1'b1;
      repeat (8) step();
      chk_bit(crs, !fd);
      body = {};
      rand_body(60);
      fork
        rx_frame();
        begin
          repeat (12) step();
          chk_bit(col, !fd);
          chk_bit(crs, 1'b1);
        end
      join
      step();
      tx_en = 1'b0;
      repeat (4) step();
    end
    $display("done carrier and collision");
    an_page(4'h1, 4'h3);
    man_nib(4'hA);
    rnd = nxt(rnd);
    man_nib(rnd[3:0]);
    repeat (3) step();
    chk_bit(tx_man, 1'b0);
    $display("done manchester");
    conclude();
  end
endmodule
